// file: logic/kwu_defs.svh
// Constants for the key-on wakeup block: register offsets, fields, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef KWU_DEFS_SVH
`define KWU_DEFS_SVH
`define KWU_ENABLE_INDEX 12'hf9a
`define KWU_CONTROL_INDEX 12'hfa0
`define KWU_STATUS_INDEX 12'hfa4
`define KWU_ENABLE_RESET 4'h0
`define KWU_ENABLE_LSB 4
`define KWU_ENABLE_MSB 7
`define KWU_CTRL_RELM_BIT 0
`define KWU_CTRL_STOP_BIT 1
`define KWU_RESP_OKAY 2'h0
`define KWU_RESP_SLVERR 2'h2
`define KWU_ADDR_W 14
`endif

// file: logic/kwu_pkg.sv
// Types shared by the key-on wakeup block.
// Assumes kwu_defs.svh is on the include path.
package kwu_pkg;
  `include "kwu_defs.svh"

  // Sleep sequencer states.
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_stop = 2'b01,
    st_warm = 2'b10
  } sleep_state_e;

  // Key pin group as it arrives from the pads.
  typedef struct packed {
    logic [3:0] key_wake_n;
    logic release_pin;
  } wake_pins_s;
endpackage : kwu_pkg

// file: logic/key_wakeup_release.sv
// Key-on wakeup release logic with an AXI4-Lite register slave.
// Assumes pads are synchronous to clk; a stopped clock is modelled by the
// clk_run output, and release detection is combinational on the pins.
// Summary of operation
// - Enable register write-only; bits 7..4 enable key pins 3..0, reset zero.
// - Each key pin enabled or disabled by its own bit independently.
// - Level mode: low on any enabled key pin releases stop; disabled ignored.
// - Main pin: high level when mode bit 1, rising edge when 0.
// - Release condition present at entry: skip stop, start warm-up at once.
`timescale 1ns/1ps
`default_nettype none
`include "kwu_defs.svh"
module key_wakeup_release
  import kwu_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data.
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Wake pins.
  input wire wake_pins_s pins,
  // Power sequencing.
  output logic clk_run,
  output logic warmup_start
);

  // Register decode on the word index; the two byte-lane bits take no part.
  // Register numbers are word indices, so the byte address is four times the index.
  // A master that issues an unaligned address still lands on the word it names.
  function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
    hit = (a[13:2] == idx);
  endfunction : hit

  // Register map, by word index:
  // enable index holds the key enables in bits 7..4 and reads back as zero.
  // control index holds the release mode in bit 0 and a self-clearing stop request in bit 1.
  // status index reports the sequencer state in bits 1..0.
  // status bits 5..2 show which enabled key pins are low right now.
  // Software reads status before a stop request to be sure no enabled key is low.
  // Any other index answers with a slave error and changes nothing.

  logic [3:0] enable_q, enable_d;
  logic relm_q, relm_d;
  logic rel_q, rel_d;
  sleep_state_e state_q, state_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [13:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic have_aw_q, have_aw_d, have_w_q, have_w_d;
  logic stop_req;
  logic warm_q, warm_d;
  logic key_level;
  logic main_level;
  logic release_now;
  logic clk_run_q, clk_run_d;

  // Release terms are pure gates on the pins so they act with the clock stopped.
  assign key_level = |(enable_q & ~pins.key_wake_n);
  assign main_level = pins.release_pin;

  // Rising edge in edge mode, high level in level mode; keys only in level mode.
  always_comb begin
    release_now = 1'b0;
    if (relm_q) begin
      release_now = main_level | key_level;
    end else begin
      release_now = main_level & ~rel_q;
    end
  end

  // Write channel: accept address and data in either order, answer after both.
  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    have_aw_d = have_aw_q;
    have_w_d = have_w_q;
    enable_d = enable_q;
    relm_d = relm_q;
    stop_req = 1'b0;
    awready_d = ~have_aw_q & ~bvalid_q & ~(s_axi_awvalid & awready_q);
    wready_d = ~have_w_q & ~bvalid_q & ~(s_axi_wvalid & wready_q);
    if (s_axi_awvalid && awready_q) begin
      awaddr_d = s_axi_awaddr;
      have_aw_d = 1'b1;
    end
    if (s_axi_wvalid && wready_q) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      have_w_d = 1'b1;
    end
    if (have_aw_q && have_w_q && !bvalid_q) begin
      have_aw_d = 1'b0;
      have_w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `KWU_RESP_OKAY;
      if (hit(awaddr_q, `KWU_ENABLE_INDEX)) begin
        if (wstrb_q[0]) begin
          enable_d = wdata_q[`KWU_ENABLE_MSB:`KWU_ENABLE_LSB];
        end
      end else if (hit(awaddr_q, `KWU_CONTROL_INDEX)) begin
        if (wstrb_q[0]) begin
          relm_d = wdata_q[`KWU_CTRL_RELM_BIT];
          stop_req = wdata_q[`KWU_CTRL_STOP_BIT];
        end
      end else begin
        bresp_d = `KWU_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Read channel; the enable register is write-only and reads as zero.
  always_comb begin
    arready_d = ~rvalid_q & ~(s_axi_arvalid & arready_q);
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = `KWU_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (hit(s_axi_araddr, `KWU_ENABLE_INDEX)) begin
        rdata_d = 32'h0000_0000;
      end else if (hit(s_axi_araddr, `KWU_CONTROL_INDEX)) begin
        rdata_d[`KWU_CTRL_RELM_BIT] = relm_q;
      end else if (hit(s_axi_araddr, `KWU_STATUS_INDEX)) begin
        rdata_d = {26'h000_0000, ~pins.key_wake_n & enable_q, state_q};
      end else begin
        rresp_d = `KWU_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Stop sequencer: entry is refused when a release condition already stands.
  // The refusal test ignores the release mode on purpose: the mode bit may be
  // written by the same access as the stop request, so the old value cannot be
  // trusted, and an enabled key already low must refuse entry in either mode.
  // The main pin's last sample is kept so an edge-mode release needs a fresh rise.
  always_comb begin
    state_d = state_q;
    warm_d = 1'b0;
    rel_d = main_level;
    case (state_q)
      st_run: begin
        if (stop_req) begin
          if (main_level || key_level) begin
            state_d = st_warm;
          end else begin
            state_d = st_stop;
          end
        end
      end
      st_stop: begin
        if (release_now) begin
          state_d = st_warm;
        end
      end
      st_warm: begin
        warm_d = 1'b1;
        state_d = st_run;
      end
      default: begin
        state_d = st_run;
      end
    endcase
    // The run flag follows the next state so it changes on the same edge as the state.
    clk_run_d = (state_d != st_stop);
  end

  // Software settings: key enables and release mode.
  // Writes are taken in every state, so a write that lands during stop changes the settings a release sees.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= `KWU_ENABLE_RESET;
      relm_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      relm_q <= relm_d;
    end
  end

  // Write channel registers.
  // Readies come up on the first edge after reset, never during it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      awaddr_q <= 14'h0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      have_aw_q <= have_aw_d;
      have_w_q <= have_w_d;
    end
  end

  // Read channel registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Sequencer registers.
  // The main pin sample resets low, its idle level, so reset makes no false edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_q <= 1'b0;
      state_q <= st_run;
      warm_q <= 1'b0;
      clk_run_q <= 1'b1;
    end else begin
      rel_q <= rel_d;
      state_q <= state_d;
      warm_q <= warm_d;
      clk_run_q <= clk_run_d;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // The run flag is its own register so no decode glitch reaches the clock gate.
  assign clk_run = clk_run_q;
  assign warmup_start = warm_q;

endmodule : key_wakeup_release
`default_nettype wire

// file: testbench/kwu_monitor.sv
// Port checker for the key wakeup block.
// Assumes it is bound to key_wakeup_release.
`timescale 1ns/1ps
`default_nettype none
module kwu_monitor
  import kwu_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register bus.
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins and power.
  input wire wake_pins_s pins,
  input wire logic clk_run,
  input wire logic warmup_start
);
  // One clock domain, so one clock and one reset serve every property.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_warm_one_cycle: assert property (warmup_start |=> !warmup_start)
    else $error("warm-up pulse too long");
  chk_warm_clock_on: assert property (warmup_start |-> clk_run)
    else $error("clock stopped during warm-up");
  chk_wake_pulse: assert property ($rose(clk_run) |-> ##[0:2] warmup_start)
    else $error("release without warm-up");
  chk_main_release: assert property (!clk_run && pins.release_pin |-> ##[1:3] clk_run)
    else $error("main pin did not release");
  chk_stay_stopped: assert property (!clk_run && !pins.release_pin && &pins.key_wake_n
    |=> !clk_run)
    else $error("release without a cause");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken before response");
endmodule : kwu_monitor
`default_nettype wire

// file: testbench/key_pad_model.sv
// Key switches and main release pin on the wake pads.
// Assumes the bench says which keys are pressed.
`timescale 1ns/1ps
`default_nettype none
module key_pad_model
  import kwu_pkg::*;
(
  // Commands from the bench.
  input wire logic [3:0] press,
  input wire logic rel_high,
  // Pads.
  output wire wake_pins_s pins
);
  // A pressed key pulls its pad low; the main pin stays low unless asked.
  // The pads are only driven from outside: the port sits as a digital input.
  // No analog source is ever put on a key pad while it is enabled.
  assign pins.key_wake_n = ~press;
  assign pins.release_pin = rel_high;
endmodule : key_pad_model
`default_nettype wire

// file: testbench/key_wakeup_release_tb.sv
// Self-checking bench for the key wakeup block.
// Assumes the package, the design, the pad model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "kwu_defs.svh"
module key_wakeup_release_tb
  import kwu_pkg::*;
();
  logic clk = 0, rst_n = 0, rel_high = 0;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0, press = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic clk_run, warmup_start;
  wake_pins_s pins;
  int mismatches = 0, checked = 0, warm_cnt = 0, n;
  key_pad_model pad (.press(press), .rel_high(rel_high), .pins(pins));
  key_wakeup_release uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pins(pins),
    .clk_run(clk_run), .warmup_start(warmup_start));
  // Clock and a count of warm-up pulses for refusal checks.
  always #2 clk = ~clk;
  always @(posedge clk) if (warmup_start === 1'b1) warm_cnt <= warm_cnt + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Each channel is released only at the edge where its ready was seen.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 2'b00, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b00, 2'b11};
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  // Requests stop in the given mode and checks the state that follows.
  task automatic go_stop(input logic relm, input logic [1:0] st);
    logic [31:0] d;
    logic [1:0] r;
    wr(`KWU_CONTROL_INDEX, {30'h0, 1'b1, relm}, 4'hf, r);
    rd(`KWU_STATUS_INDEX, d, r);
    chk(d[1:0], st);
  endtask : go_stop
  task automatic wake;
    repeat (10) if (clk_run !== 1'b1) @(posedge clk);
  endtask : wake
  task automatic s_keys;
    logic [31:0] d;
    logic [1:0] r;
    press <= 4'hf;
    rd(`KWU_STATUS_INDEX, d, r);
    chk(d[5:2], 4'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`KWU_ENABLE_INDEX, 32'h0000_0010 << i, 4'hf, r);
      rd(`KWU_STATUS_INDEX, d, r);
      chk(d[5:2], 4'h1 << i);
      rd(`KWU_ENABLE_INDEX, d, r);
      chk(d, 32'h0000_0000);
    end
    wr(`KWU_ENABLE_INDEX, 32'h0000_00f0, 4'h0, r);
    rd(`KWU_STATUS_INDEX, d, r);
    chk(d[5:2], 4'h8);
    wr(12'h100, 32'h0000_00f0, 4'hf, r);
    chk(r, `KWU_RESP_SLVERR);
    rd(12'h100, d, r);
    chk(r, `KWU_RESP_SLVERR);
  endtask : s_keys
  task automatic s_refuse;
    n = warm_cnt;
    go_stop(1'b1, 2'd0);
    chk(warm_cnt - n, 1);
    press <= 4'h0;
    rel_high <= 1'b1;
    go_stop(1'b0, 2'd0);
    chk(warm_cnt - n, 2);
    rel_high <= 1'b0;
  endtask : s_refuse
  task automatic s_level;
    logic [31:0] d;
    logic [1:0] r;
    rd(`KWU_STATUS_INDEX, d, r);
    chk(d[5:2], 4'h0);
    go_stop(1'b1, 2'd1);
    chk(clk_run, 1'b0);
    press <= 4'h7;
    repeat (5) @(posedge clk);
    chk(clk_run, 1'b0);
    press <= 4'h8;
    wake();
    chk(clk_run, 1'b1);
    press <= 4'h0;
    go_stop(1'b1, 2'd1);
    rel_high <= 1'b1;
    wake();
    chk(clk_run, 1'b1);
    rel_high <= 1'b0;
  endtask : s_level
  task automatic s_edge;
    logic [1:0] r;
    wr(`KWU_ENABLE_INDEX, 32'h0000_0000, 4'hf, r);
    go_stop(1'b0, 2'd1);
    rel_high <= 1'b1;
    wake();
    chk(clk_run, 1'b1);
  endtask : s_edge
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_keys();
    s_refuse();
    s_level();
    s_edge();
    give_verdict();
  end
  // The whole run needs little more than a hundred cycles; this cuts a hang short.
  initial begin
    #80000;
    mismatches++;
    give_verdict();
  end
endmodule : key_wakeup_release_tb
bind key_wakeup_release kwu_monitor mon (.clk(clk), .rst_n(rst_n),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .pins(pins), .clk_run(clk_run), .warmup_start(warmup_start));
`default_nettype wire
